//--- hdl/cise_defines.svh
/*
  Constants for the instruction subset execution unit: widths, depths,
  reset values. Assumes inclusion by bare name from the core.
*/
`ifndef CISE_DEFINES_SVH
`define CISE_DEFINES_SVH

`define CISE_DATA_W        8
`define CISE_PC_W          15
`define CISE_LATCH_W       7
`define CISE_FILE_AW       7
`define CISE_FILE_DEPTH    128
`define CISE_STACK_DEPTH   16
`define CISE_ZERO_BYTE     8'h00
`define CISE_ONE_BYTE      8'h01
`define CISE_PC_RST        15'h0000
`define CISE_PC_STEP       15'h0001
`define CISE_LATCH_RST     7'h00
`define CISE_DEST_ACC      1'b0
`define CISE_DEST_FILE     1'b1

`endif

//--- hdl/cise_pkg.sv
/*
  Types for the instruction subset execution unit: opcodes and the
  sequencer states. Assumes cise_defines.svh is compiled with it.
*/
package cise_pkg;

  // instruction selector presented by the fetch/decode stage
  typedef enum logic [2:0] {
    CISE_OP_NOP,
    CISE_OP_CALL_VIA_ACCUMULATOR,
    CISE_OP_COMPLEMENT_FILE,
    CISE_OP_CLEAR_FILE_REGISTER,
    CISE_OP_CLEAR_ACCUMULATOR,
    CISE_OP_DECREMENT_FILE,
    CISE_OP_DECREMENT_SKIP_IF_NULL,
    CISE_OP_INCREMENT_SKIP_IF_NULL
  } cise_op_t;

  typedef enum logic [1:0] {
    CISE_ST_EXEC,
    CISE_ST_CALL2,
    CISE_ST_FLUSH
  } cise_state_t;

endpackage

//--- hdl/cise_exec.sv
/*
  Execution unit for a subset of an 8-bit core's instructions: computed
  call through the accumulator, complement, clears, decrement and the
  increment/decrement skip-if-zero operations on a 128-byte file.
  Assumes decode logic on the same clock presents one instruction with a
  valid strobe and holds it until ready_o is seen high.
*/
`timescale 1ns/1ps
`include "cise_defines.svh"

module cise_exec #(
  parameter int STACK_DEPTH = `CISE_STACK_DEPTH
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // instruction from decode
  input  wire logic                       instr_valid_i,
  input  wire cise_pkg::cise_op_t         instr_op_i,
  input  wire logic [`CISE_FILE_AW-1:0]   instr_addr_i,
  input  wire logic                       instr_dest_i,
  // side loads from the rest of the core
  input  wire logic                       acc_load_i,
  input  wire logic [`CISE_DATA_W-1:0]    acc_load_data_i,
  input  wire logic                       latch_load_i,
  input  wire logic [`CISE_LATCH_W-1:0]   latch_load_data_i,
  input  wire logic                       file_load_i,
  input  wire logic [`CISE_FILE_AW-1:0]   file_load_addr_i,
  input  wire logic [`CISE_DATA_W-1:0]    file_load_data_i,
  // file inspection port
  input  wire logic [`CISE_FILE_AW-1:0]   file_rd_addr_i,
  output logic      [`CISE_DATA_W-1:0]    file_rd_data_o,
  // core state
  output logic                            ready_o,
  output logic      [`CISE_DATA_W-1:0]    acc_o,
  output logic                            zero_o,
  output logic      [`CISE_PC_W-1:0]      pc_o,
  output logic      [`CISE_LATCH_W-1:0]   latch_o,
  output logic      [`CISE_PC_W-1:0]      stack_top_o,
  output logic                            push_o,
  output logic                            skip_o
);

  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  logic [`CISE_DATA_W-1:0] file_mem [`CISE_FILE_DEPTH];
  logic [`CISE_PC_W-1:0]   stack_mem [STACK_DEPTH];

  cise_pkg::cise_state_t   state_r;
  cise_pkg::cise_state_t   state_nxt;
  logic [`CISE_DATA_W-1:0] acc_r;
  logic                    zero_r;
  logic [`CISE_PC_W-1:0]   pc_r;
  logic [`CISE_PC_W-1:0]   pc_nxt;
  logic [`CISE_LATCH_W-1:0] latch_r;
  logic [`CISE_PC_W-1:0]   stack_top_r;
  logic [SP_W-1:0]         sp_r;
  logic                    push_r;
  logic                    skip_r;
  logic                    ready_r;
  logic [`CISE_DATA_W-1:0] rd_data_r;

  // decode
  wire take = instr_valid_i && (state_r == cise_pkg::CISE_ST_EXEC);
  wire op_call = (instr_op_i == cise_pkg::CISE_OP_CALL_VIA_ACCUMULATOR);
  wire op_complement_file = (instr_op_i == cise_pkg::CISE_OP_COMPLEMENT_FILE);
  wire op_clear_file_register = (instr_op_i == cise_pkg::CISE_OP_CLEAR_FILE_REGISTER);
  wire op_clear_accumulator = (instr_op_i == cise_pkg::CISE_OP_CLEAR_ACCUMULATOR);
  wire op_decrement_file = (instr_op_i == cise_pkg::CISE_OP_DECREMENT_FILE);
  wire op_dsz  = (instr_op_i == cise_pkg::CISE_OP_DECREMENT_SKIP_IF_NULL);
  wire op_isz  = (instr_op_i == cise_pkg::CISE_OP_INCREMENT_SKIP_IF_NULL);
  wire op_routed = op_complement_file || op_decrement_file || op_dsz || op_isz;

  // datapath
  wire [`CISE_DATA_W-1:0] operand = file_mem[instr_addr_i];
  wire [`CISE_DATA_W-1:0] res_inv = ~operand;
  wire [`CISE_DATA_W-1:0] res_dec = operand - `CISE_ONE_BYTE;
  wire [`CISE_DATA_W-1:0] res_inc = operand + `CISE_ONE_BYTE;
  wire [`CISE_DATA_W-1:0] result  = op_complement_file              ? res_inv :
                                    (op_decrement_file || op_dsz)  ? res_dec :
                                    op_isz               ? res_inc :
                                                           `CISE_ZERO_BYTE;
  wire res_zero = (result == `CISE_ZERO_BYTE);

  // destination routing
  wire to_file = take && (op_clear_file_register ||
                 (op_routed && instr_dest_i == `CISE_DEST_FILE));
  wire to_acc  = take && (op_clear_accumulator ||
                 (op_routed && instr_dest_i == `CISE_DEST_ACC));

  // zero flag: clears force it, complement and decrement follow the result, others leave it
  wire z_force  = take && (op_clear_file_register || op_clear_accumulator);
  wire z_follow = take && (op_complement_file || op_decrement_file);
  wire skip_hit = take && (op_dsz || op_isz) && res_zero;
  wire call_go  = take && op_call;

  wire [`CISE_PC_W-1:0] pc_inc    = pc_r + `CISE_PC_STEP;
  wire [`CISE_PC_W-1:0] call_dest = {latch_r, acc_r};

  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    case (state_r)
      cise_pkg::CISE_ST_EXEC: begin
        if (call_go) begin
          state_nxt = cise_pkg::CISE_ST_CALL2;
        end else if (take) begin
          pc_nxt = pc_inc;
          if (skip_hit) begin
            state_nxt = cise_pkg::CISE_ST_FLUSH;
          end
        end
      end
      cise_pkg::CISE_ST_CALL2: begin
        pc_nxt    = call_dest;
        state_nxt = cise_pkg::CISE_ST_EXEC;
      end
      cise_pkg::CISE_ST_FLUSH: begin
        // the discarded instruction's slot still advances past it
        pc_nxt    = pc_inc;
        state_nxt = cise_pkg::CISE_ST_EXEC;
      end
      default: begin
        state_nxt = cise_pkg::CISE_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= cise_pkg::CISE_ST_EXEC;
      pc_r    <= `CISE_PC_RST;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
    end
  end

  // ready is a flop copy of the next state, so the port carries no decode glitch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= (state_nxt == cise_pkg::CISE_ST_EXEC);
    end
  end

  // accumulator: instruction result has priority over a side load
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= `CISE_ZERO_BYTE;
    end else if (to_acc) begin
      acc_r <= result;
    end else if (acc_load_i && !take) begin
      acc_r <= acc_load_data_i;
    end
  end

  // call and skip operations leave the flag alone
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zero_r <= 1'b0;
    end else if (z_force) begin
      zero_r <= 1'b1;
    end else if (z_follow) begin
      zero_r <= res_zero;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_r <= `CISE_LATCH_RST;
    end else if (latch_load_i) begin
      latch_r <= latch_load_data_i;
    end
  end

  // file has no reset; it is data memory, preloaded by the core
  always_ff @(posedge clk_i) begin
    if (to_file) begin
      file_mem[instr_addr_i] <= result;
    end else if (file_load_i) begin
      file_mem[file_load_addr_i] <= file_load_data_i;
    end
  end

  // return stack: wraps silently, overflow handling lives elsewhere
  always_ff @(posedge clk_i) begin
    if (call_go) begin
      stack_mem[sp_r] <= pc_inc;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sp_r        <= '0;
      stack_top_r <= `CISE_PC_RST;
      push_r      <= 1'b0;
    end else begin
      push_r <= call_go;
      if (call_go) begin
        sp_r        <= sp_r + SP_W'(1);
        stack_top_r <= pc_inc;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      skip_r    <= 1'b0;
      rd_data_r <= `CISE_ZERO_BYTE;
    end else begin
      skip_r    <= skip_hit;
      rd_data_r <= file_mem[file_rd_addr_i];
    end
  end

  assign ready_o        = ready_r;
  assign acc_o          = acc_r;
  assign zero_o         = zero_r;
  assign pc_o           = pc_r;
  assign latch_o        = latch_r;
  assign stack_top_o    = stack_top_r;
  assign push_o         = push_r;
  assign skip_o         = skip_r;
  assign file_rd_data_o = rd_data_r;

endmodule

//--- verif/cise_exec_monitor.sv
/*
  Checker for cise_exec: call, skip and flag timing at the ports.
  Assumes it is bound to cise_exec and sees that module's ports only.
*/
`timescale 1ns/1ps
module cise_exec_monitor (
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // instruction
  input wire logic               instr_valid_i,
  input wire cise_pkg::cise_op_t instr_op_i,
  input wire logic               instr_dest_i,
  // core state
  input wire logic               ready_o,
  input wire logic [7:0]         acc_o,
  input wire logic               zero_o,
  input wire logic [14:0]        pc_o,
  input wire logic [6:0]         latch_o,
  input wire logic [14:0]        stack_top_o,
  input wire logic               push_o,
  input wire logic               skip_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = instr_valid_i && ready_o;
  wire call = take && instr_op_i == cise_pkg::CISE_OP_CALL_VIA_ACCUMULATOR;
  wire skop = take && (instr_op_i == cise_pkg::CISE_OP_DECREMENT_SKIP_IF_NULL
                    || instr_op_i == cise_pkg::CISE_OP_INCREMENT_SKIP_IF_NULL);
  wire zop  = take && !instr_dest_i && (instr_op_i == cise_pkg::CISE_OP_COMPLEMENT_FILE
                    || instr_op_i == cise_pkg::CISE_OP_DECREMENT_FILE);
  wire clear_accumulator = take && instr_op_i == cise_pkg::CISE_OP_CLEAR_ACCUMULATOR;
  a_call_push_ret: assert property (call |=> push_o && stack_top_o == $past(pc_o) + 15'h0001)
    else $error("call did not push the next address");
  a_call_pc_low: assert property (call |-> ##2 pc_o[7:0] == $past(acc_o))
    else $error("call target low byte wrong");
  a_call_pc_high: assert property (call |-> ##2 pc_o[14:8] == $past(latch_o))
    else $error("call target high bits wrong");
  a_call_two_cyc: assert property (call |=> !ready_o ##1 ready_o)
    else $error("call did not take two cycles");
  a_call_flags: assert property (call |=> $stable(zero_o) [*2])
    else $error("call changed the zero flag");
  a_clear_acc: assert property (clear_accumulator |=> acc_o == 8'h00 && zero_o)
    else $error("clear accumulator result wrong");
  a_skip_flags: assert property (skop |=> $stable(zero_o))
    else $error("skip op changed the zero flag");
  a_skip_slot: assert property (skip_o |-> !ready_o ##1 (ready_o && pc_o == $past(pc_o) + 15'h0001))
    else $error("skipped slot not a single no-op");
  a_zero_track: assert property (zop |=> zero_o == (acc_o == 8'h00))
    else $error("zero flag does not follow result");
endmodule

bind cise_exec cise_exec_monitor u_mon (.clk_i, .rst_i, .instr_valid_i, .instr_op_i,
  .instr_dest_i, .ready_o, .acc_o, .zero_o, .pc_o, .latch_o, .stack_top_o, .push_o, .skip_o);

//--- verif/test_cpu_instruction_subset_exec.sv
/*
  Self-checking bench for cise_exec: one task per scenario.
  Assumes the design, package and bound checker are compiled first.
*/
`timescale 1ns/1ps
module test_cpu_instruction_subset_exec;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               instr_valid_i = 1'b0, instr_dest_i = 1'b0;
  cise_pkg::cise_op_t instr_op_i = cise_pkg::CISE_OP_NOP;
  logic [6:0]         instr_addr_i = 7'h00, file_load_addr_i = 7'h00, file_rd_addr_i = 7'h00;
  logic [6:0]         latch_load_data_i = 7'h00, latch_o;
  logic               acc_load_i = 1'b0, latch_load_i = 1'b0, file_load_i = 1'b0;
  logic [7:0]         acc_load_data_i = 8'h00, file_load_data_i = 8'h00, file_rd_data_o, acc_o;
  logic [14:0]        pc_o, stack_top_o, pc0, st;
  logic               ready_o, zero_o, push_o, skip_o, sk, pu;
  int                 miscompares = 0, tests_run = 0;

  cise_exec uut (.clk_i, .rst_i, .instr_valid_i, .instr_op_i, .instr_addr_i, .instr_dest_i,
    .acc_load_i, .acc_load_data_i, .latch_load_i, .latch_load_data_i, .file_load_i,
    .file_load_addr_i, .file_load_data_i, .file_rd_addr_i, .file_rd_data_o, .ready_o,
    .acc_o, .zero_o, .pc_o, .latch_o, .stack_top_o, .push_o, .skip_o);

  always #50 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [14:0] seen, input logic [14:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one instruction; pulses of the cycle after the take are captured
  task automatic run(input cise_pkg::cise_op_t op, input logic [6:0] a, input logic d);
    int n;
    @(negedge clk_i);
    pc0 = pc_o;
    instr_valid_i = 1'b1;
    instr_op_i = op;
    instr_addr_i = a;
    instr_dest_i = d;
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    sk = skip_o;
    pu = push_o;
    st = stack_top_o;
    n = 0;
    while (ready_o !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task automatic ld(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    file_load_i = 1'b1;
    file_load_addr_i = a;
    file_load_data_i = d;
    @(negedge clk_i);
    file_load_i = 1'b0;
  endtask

  task automatic ldw(input logic [7:0] w, input logic [6:0] h);
    @(negedge clk_i);
    acc_load_i = 1'b1;
    acc_load_data_i = w;
    latch_load_i = 1'b1;
    latch_load_data_i = h;
    @(negedge clk_i);
    acc_load_i = 1'b0;
    latch_load_i = 1'b0;
  endtask

  // read port is registered: one edge before the data is valid
  task automatic rdf(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    file_rd_addr_i = a;
    @(negedge clk_i);
    chk("file", file_rd_data_o, exp);
  endtask

  task automatic t_complement_file();
    ld(7'h05, 8'h0f);
    run(cise_pkg::CISE_OP_COMPLEMENT_FILE, 7'h05, 1'b0);
    chk("complement_file acc", acc_o, 15'h00f0);
    chk("complement_file z", zero_o, 15'h0000);
    run(cise_pkg::CISE_OP_COMPLEMENT_FILE, 7'h05, 1'b1);
    rdf(7'h05, 8'hf0);
    ld(7'h06, 8'hff);
    run(cise_pkg::CISE_OP_COMPLEMENT_FILE, 7'h06, 1'b0);
    chk("complement_file z1", zero_o, 15'h0001);
  endtask

  task automatic t_clr();
    ld(7'h7f, 8'h55);
    run(cise_pkg::CISE_OP_CLEAR_FILE_REGISTER, 7'h7f, 1'b0);
    chk("clear_file_register z", zero_o, 15'h0001);
    rdf(7'h7f, 8'h00);
    run(cise_pkg::CISE_OP_COMPLEMENT_FILE, 7'h05, 1'b0);
    run(cise_pkg::CISE_OP_CLEAR_ACCUMULATOR, 7'h00, 1'b0);
    chk("clear_accumulator acc", acc_o, 15'h0000);
    chk("clear_accumulator z", zero_o, 15'h0001);
  endtask

  task automatic t_dec();
    ld(7'h01, 8'h01);
    run(cise_pkg::CISE_OP_DECREMENT_FILE, 7'h01, 1'b0);
    chk("decrement_file acc", acc_o, 15'h0000);
    ld(7'h02, 8'h00);
    run(cise_pkg::CISE_OP_DECREMENT_FILE, 7'h02, 1'b1);
    chk("decrement_file z", zero_o, 15'h0000);
    rdf(7'h02, 8'hff);
  endtask

  task automatic t_skip();
    ld(7'h03, 8'h02);
    run(cise_pkg::CISE_OP_DECREMENT_SKIP_IF_NULL, 7'h03, 1'b1);
    chk("dsz pc", pc_o, pc0 + 15'h0001);
    rdf(7'h03, 8'h01);
    run(cise_pkg::CISE_OP_DECREMENT_SKIP_IF_NULL, 7'h03, 1'b0);
    chk("dsz skip", sk, 15'h0001);
    chk("dsz pc2", pc_o, pc0 + 15'h0002);
    chk("dsz z", zero_o, 15'h0000);
    ld(7'h04, 8'hff);
    run(cise_pkg::CISE_OP_INCREMENT_SKIP_IF_NULL, 7'h04, 1'b1);
    chk("isz pc2", pc_o, pc0 + 15'h0002);
    rdf(7'h04, 8'h00);
  endtask

  task automatic t_call();
    ldw(8'ha5, 7'h7f);
    run(cise_pkg::CISE_OP_CALL_VIA_ACCUMULATOR, 7'h00, 1'b0);
    chk("push", pu, 15'h0001);
    chk("ret", st, pc0 + 15'h0001);
    chk("target", pc_o, 15'h7fa5);
    chk("call z", zero_o, 15'h0000);
    chk("latch", latch_o, 15'h007f);
    chk("call acc", acc_o, 15'h00a5);
    run(cise_pkg::CISE_OP_NOP, 7'h00, 1'b0);
    chk("nop pc", pc_o, pc0 + 15'h0001);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_complement_file();
    t_clr();
    t_dec();
    t_skip();
    t_call();
    finish_test();
  end

  // whole run is about sixty cycles
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule
